// *** src/soi_pkg.sv ***
// shared constants and types for the serial output interface configuration link
package soi_pkg;

   // device register offsets on the link
   localparam logic [6:0] SOI_ADDR_CLKBUF = 7'h18;
   localparam logic [6:0] SOI_ADDR_FRAME_CLOCK   = 7'h19;
   localparam logic [6:0] SOI_ADDR_RES    = 7'h1b;
   localparam logic [6:0] SOI_ADDR_DLY    = 7'h1e;

   // register defaults and writable bits, everything else is reserved
   localparam logic [7:0] SOI_REG_RESET   = 8'h00;
   localparam logic [7:0] SOI_CLKBUF_MASK = 8'h10;
   localparam logic [7:0] SOI_FRAME_CLOCK_MASK   = 8'h92;
   localparam logic [7:0] SOI_RES_MASK    = 8'hf8;
   localparam logic [7:0] SOI_DLY_MASK    = 8'h30;

   // field positions
   localparam int SOI_RETEN_BIT  = 4;
   localparam int SOI_FSRC_BIT   = 7;
   localparam int SOI_FDIV_BIT   = 4;
   localparam int SOI_FPIN_BIT   = 1;
   localparam int SOI_MAPEN_BIT  = 7;
   localparam int SOI_B20_BIT    = 6;
   localparam int SOI_RESF_HI    = 5;
   localparam int SOI_RESF_LO    = 3;
   localparam int SOI_DLYF_HI    = 5;
   localparam int SOI_DLYF_LO    = 4;

   // resolution codes and output widths in bits
   localparam logic [2:0] SOI_RES_18   = 3'h0;
   localparam logic [2:0] SOI_RES_16   = 3'h1;
   localparam logic [2:0] SOI_RES_14   = 3'h2;
   localparam logic [4:0] SOI_W20      = 5'h14;
   localparam logic [4:0] SOI_W18      = 5'h12;
   localparam logic [4:0] SOI_W16      = 5'h10;
   localparam logic [4:0] SOI_W14      = 5'h0e;
   localparam logic [4:0] SOI_W_NATIVE = 5'h0e;

   // output clock delay codes and their step counts
   localparam logic [1:0] SOI_DLY_NONE = 2'h0;
   localparam logic [1:0] SOI_DLY_ADV  = 2'h1;
   localparam logic [1:0] SOI_DLY_D1   = 2'h2;
   localparam logic [2:0] SOI_STEP_0   = 3'h0;
   localparam logic [2:0] SOI_STEP_M1  = 3'h7;
   localparam logic [2:0] SOI_STEP_P1  = 3'h1;
   localparam logic [2:0] SOI_STEP_P2  = 3'h2;

   // link frame: read flag, 7-bit address, 8-bit data, msb first
   localparam int         SOI_FRAME_W   = 16;
   localparam int         SOI_RW_BIT    = 15;
   localparam int         SOI_ADDR_LO   = 8;
   localparam logic [3:0] SOI_HDR_LAST  = 4'h7;
   localparam logic [3:0] SOI_BIT_LAST  = 4'hf;

   // host link clock divider: one link period is eight pclk cycles
   localparam logic [2:0] SOI_PH_PRE    = 3'h3;
   localparam logic [2:0] SOI_PH_LAST   = 3'h7;

   // host apb map
   localparam logic [11:0] SOI_APB_CMD  = 12'h000;
   localparam logic [11:0] SOI_APB_STAT = 12'h004;
   localparam logic [11:0] SOI_APB_RDAT = 12'h008;
   localparam int          SOI_BUSY_BIT = 0;
   localparam int          SOI_DONE_BIT = 1;

   typedef enum logic [1:0] {
      SOI_BYPASS  = 2'h0,
      SOI_REAL    = 2'h1,
      SOI_COMPLEX = 2'h2
   } soi_decim_t;

   typedef enum logic [1:0] {
      SOI_IDLE  = 2'b00,
      SOI_SHIFT = 2'b01,
      SOI_TAIL  = 2'b11
   } soi_hstate_t;

endpackage

// *** src/soi_link_if.sv ***
// serial configuration link between host controller and converter
`timescale 1ns/1ps
`default_nettype none
interface soi_link_if;
   logic sclk;
   logic sen_n;
   logic sdi;
   logic sdo_out;
   logic sdo_oe;
   logic sdo;

   // the read-back line is pulled low when nobody drives it
   assign sdo = sdo_oe ? sdo_out : 1'b0;

   modport dev (
      input  sclk,
      input  sen_n,
      input  sdi,
      output sdo_out,
      output sdo_oe
   );

   modport host (
      output sclk,
      output sen_n,
      output sdi,
      input  sdo
   );
endinterface
`default_nettype wire

// *** src/soi_device.sv ***
// converter end: serial output interface configuration registers
`timescale 1ns/1ps
`default_nettype none
module soi_device
   import soi_pkg::*;
(
   soi_link_if.dev          link,
   input  wire logic        presetn,
   input  wire soi_decim_t  decim_mode,
   output logic             returned_clock_input_enable,
   output logic             frame_clock_source_select,
   output logic             frame_clock_divide_select,
   output logic             frame_clock_pin_enable,
   output logic             mapper_enable,
   output logic             twenty_bit_output_enable,
   output logic [2:0]       mapper_resolution_select,
   output logic [4:0]       output_width,
   output logic             resolution_unsupported,
   output logic [1:0]       output_clock_delay_select,
   output logic [2:0]       output_clock_delay_steps
);

   ////////////////////////////////////////////////////////////////////////////
   // register storage and read-back decode

   logic [7:0] input_clock_buffer_ctrl;
   logic [7:0] frame_clock_ctrl;
   logic [7:0] output_resolution_ctrl;
   logic [7:0] output_clock_delay_ctrl;

   // reserved positions always read back as zero
   function automatic logic [7:0] soi_read(input logic [6:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         SOI_ADDR_CLKBUF: v = input_clock_buffer_ctrl;
         SOI_ADDR_FRAME_CLOCK:   v = frame_clock_ctrl;
         SOI_ADDR_RES:    v = output_resolution_ctrl;
         SOI_ADDR_DLY:    v = output_clock_delay_ctrl;
         default:         v = 8'h00;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // link framing, all on the link clock
   // frame layout, msb first: read flag, seven address bits, eight data bits;
   // the header is complete at the eighth rising edge, the data byte at the
   // sixteenth, and a frame cut short before that changes no register

   logic [14:0] shift_in;
   logic [3:0]  bit_cnt;
   logic        rd_frame;
   logic [6:0]  frame_addr;
   logic [7:0]  shift_out;
   logic        drive;

   // byte made of the last seven stored bits and the bit now on the line
   function automatic logic [7:0] frame_byte(input logic [14:0] s, input logic b);
      return {s[6:0], b};
   endfunction

   wire       frame_rst  = !presetn || link.sen_n;
   wire [7:0] hdr_now    = frame_byte(shift_in, link.sdi);
   wire       at_hdr     = bit_cnt == SOI_HDR_LAST;
   wire       at_last    = bit_cnt == SOI_BIT_LAST;
   wire [7:0] wr_data    = frame_byte(shift_in, link.sdi);
   wire       wr_commit  = at_last && !rd_frame;

   // frame state is cleared by enable going high, since the link clock
   // stops between frames and cannot be relied on to flush it
   always_ff @(posedge link.sclk or posedge frame_rst) begin
      if (frame_rst) begin
         shift_in   <= 15'h0000;
         bit_cnt    <= 4'h0;
         rd_frame   <= 1'b0;
         frame_addr <= 7'h00;
         shift_out  <= 8'h00;
         drive      <= 1'b0;
      end else begin
         shift_in <= {shift_in[13:0], link.sdi};
         bit_cnt  <= bit_cnt + 4'h1;
         if (at_hdr) begin
            rd_frame   <= hdr_now[7];
            frame_addr <= hdr_now[6:0];
            shift_out  <= soi_read(hdr_now[6:0]);
            drive      <= hdr_now[7];
         end else begin
            shift_out <= {shift_out[6:0], 1'b0};
         end
         if (at_last) begin
            drive <= 1'b0; // release line after the last data bit
         end
      end
   end

   // read data leaves msb first, valid from the eighth rising edge on
   assign link.sdo_out = shift_out[7];
   assign link.sdo_oe  = drive;

   ////////////////////////////////////////////////////////////////////////////
   // register writes, committed on the sixteenth rising edge of a write frame

   // only documented bits are stored, so reserved writes have no effect
   // a write to an unknown address is dropped, and reading it returns zero
   always_ff @(posedge link.sclk or negedge presetn) begin
      if (!presetn) begin
         input_clock_buffer_ctrl <= SOI_REG_RESET;
         frame_clock_ctrl        <= SOI_REG_RESET;
         output_resolution_ctrl  <= SOI_REG_RESET;
         output_clock_delay_ctrl <= SOI_REG_RESET;
      end else if (wr_commit && !link.sen_n) begin
         case (frame_addr)
            SOI_ADDR_CLKBUF: input_clock_buffer_ctrl <= wr_data & SOI_CLKBUF_MASK;
            SOI_ADDR_FRAME_CLOCK:   frame_clock_ctrl        <= wr_data & SOI_FRAME_CLOCK_MASK;
            SOI_ADDR_RES:    output_resolution_ctrl  <= wr_data & SOI_RES_MASK;
            SOI_ADDR_DLY:    output_clock_delay_ctrl <= wr_data & SOI_DLY_MASK;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clocking controls

   // the returned clock input enable follows the single stored enable bit of the buffer register
   assign returned_clock_input_enable =
      input_clock_buffer_ctrl[SOI_RETEN_BIT];

   // 0: converter core makes the frame clock, 1: decimation block does
   assign frame_clock_source_select =
      frame_clock_ctrl[SOI_FSRC_BIT];
   assign frame_clock_divide_select =
      frame_clock_ctrl[SOI_FDIV_BIT];

   // 1 turns one data pin into the frame clock pin
   assign frame_clock_pin_enable = frame_clock_ctrl[SOI_FPIN_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // output bit mapper

   assign mapper_enable            = output_resolution_ctrl[SOI_MAPEN_BIT];
   assign twenty_bit_output_enable = output_resolution_ctrl[SOI_B20_BIT];
   assign mapper_resolution_select =
      output_resolution_ctrl[SOI_RESF_HI:SOI_RESF_LO];

   // decim_mode is a static level from the data path, decoded as it stands
   wire in_bypass   = decim_mode == SOI_BYPASS;
   // in bypass the field only counts once the mapper is enabled; under
   // decimation the field narrows the output whatever the mapper bit holds
   wire field_used  = in_bypass ? mapper_enable : 1'b1;
   wire code_known  = mapper_resolution_select == SOI_RES_18 ||
                      mapper_resolution_select == SOI_RES_16 ||
                      mapper_resolution_select == SOI_RES_14;

   logic [4:0] field_width;

   // resolution code decode, unknown codes fall back to 18 bits
   always_comb begin
      case (mapper_resolution_select)
         SOI_RES_18: field_width = SOI_W18;
         SOI_RES_16: field_width = SOI_W16;
         SOI_RES_14: field_width = SOI_W14;
         default:    field_width = SOI_W18;
      endcase
   end

   // 20-bit output overrides the field, native width when mapper is off in bypass
   assign output_width = twenty_bit_output_enable ? SOI_W20 :
                         field_used ? field_width :
                         SOI_W_NATIVE;

   // flags an unsupported code only where the field actually steers output
   assign resolution_unsupported =
      !twenty_bit_output_enable && field_used && !code_known;

   ////////////////////////////////////////////////////////////////////////////
   // output clock delay, steps as a signed count, negative means advanced

   assign output_clock_delay_select =
      output_clock_delay_ctrl[SOI_DLYF_HI:SOI_DLYF_LO];

   always_comb begin
      case (output_clock_delay_select)
         SOI_DLY_NONE: output_clock_delay_steps = SOI_STEP_0;
         SOI_DLY_ADV:  output_clock_delay_steps = SOI_STEP_M1;
         SOI_DLY_D1:   output_clock_delay_steps = SOI_STEP_P1;
         default:      output_clock_delay_steps = SOI_STEP_P2;
      endcase
   end

endmodule
`default_nettype wire

// *** src/soi_host.sv ***
// host end: apb-driven controller that writes and reads converter registers
`timescale 1ns/1ps
`default_nettype none
module soi_host
   import soi_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   soi_link_if.host         link
);

   ////////////////////////////////////////////////////////////////////////////
   // apb decode

   soi_hstate_t state;
   logic        done;
   logic [7:0]  rd_data;

   wire hit_cmd  = paddr == SOI_APB_CMD;
   wire hit_stat = paddr == SOI_APB_STAT;
   wire hit_rdat = paddr == SOI_APB_RDAT;
   wire mapped   = hit_cmd || hit_stat || hit_rdat;
   wire access   = psel && penable;
   wire busy     = state != SOI_IDLE;
   // a command written while busy is dropped, software polls busy first
   wire start    = access && pwrite && hit_cmd && !busy;
   wire clr_done = access && pwrite && hit_stat && pwdata[SOI_DONE_BIT];
   wire finish;

   assign pready  = 1'b1;
   assign pslverr = access && !mapped;

   // read data is captured in the setup cycle so it is steady in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= 32'h0000_0000;
         if (hit_stat) begin
            prdata[SOI_BUSY_BIT] <= busy;
            prdata[SOI_DONE_BIT] <= done;
         end else if (hit_rdat) begin
            prdata[7:0] <= rd_data;
         end
      end
   end

   // completion flag: a finish in the same cycle as a clear wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done <= 1'b0;
      end else if (finish) begin
         done <= 1'b1;
      end else if (clr_done) begin
         done <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read-back line synchroniser, accepted once stages two and three agree

   logic sdo_s1;
   logic sdo_s2;
   logic sdo_s3;
   logic sdo_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sdo_s1 <= 1'b0;
         sdo_s2 <= 1'b0;
         sdo_s3 <= 1'b0;
         sdo_q  <= 1'b0;
      end else begin
         sdo_s1 <= link.sdo;
         sdo_s2 <= sdo_s1;
         sdo_s3 <= sdo_s2;
         if (sdo_s2 == sdo_s3) begin
            sdo_q <= sdo_s3;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer; the link clock is pclk divided by eight

   logic [15:0] shift;
   logic [3:0]  bit_idx;
   logic [2:0]  ph;
   logic        sclk_r;
   logic        sen_n_r;
   logic        is_read;

   wire rise_next = state == SOI_SHIFT && ph == SOI_PH_PRE;
   wire fall_next = state == SOI_SHIFT && ph == SOI_PH_LAST;
   assign finish  = state == SOI_TAIL && ph == SOI_PH_PRE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= SOI_IDLE;
         shift   <= 16'h0000;
         bit_idx <= 4'h0;
         ph      <= 3'h0;
         sclk_r  <= 1'b0;
         sen_n_r <= 1'b1;
         rd_data <= 8'h00;
      end else begin
         ph <= ph + 3'h1;
         case (state)
            SOI_IDLE: begin
               ph <= 3'h0;
               if (start) begin
                  shift   <= pwdata[15:0];
                  bit_idx <= 4'h0;
                  sen_n_r <= 1'b0;
                  state   <= SOI_SHIFT;
               end
            end
            SOI_SHIFT: begin
               if (rise_next) begin
                  sclk_r <= 1'b1;
               end
               if (fall_next) begin
                  sclk_r <= 1'b0;
                  ph     <= 3'h0;
                  if (bit_idx == SOI_BIT_LAST) begin
                     state <= SOI_TAIL;
                  end else begin
                     bit_idx <= bit_idx + 4'h1;
                     shift   <= {shift[14:0], shift[15]};
                  end
               end
            end
            SOI_TAIL: begin
               if (finish) begin
                  sen_n_r <= 1'b1;
                  state   <= SOI_IDLE;
               end
            end
            default: begin
               state   <= SOI_IDLE;
               sen_n_r <= 1'b1;
               sclk_r  <= 1'b0;
            end
         endcase
         // read bits are sampled on the same pclk edge that raises the link clock
         if (rise_next && is_read && bit_idx > SOI_HDR_LAST) begin
            rd_data <= {rd_data[6:0], sdo_q};
         end
      end
   end

   // read flag latched at command time, the shift register rotates under it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         is_read <= 1'b0;
      end else if (start) begin
         is_read <= pwdata[SOI_RW_BIT];
      end
   end

   assign link.sclk  = sclk_r;
   assign link.sen_n = sen_n_r;
   assign link.sdi   = shift[SOI_RW_BIT];

endmodule
`default_nettype wire

// *** verif/soi_link_properties.sv ***
// checker: framing and read-back timing on the configuration link
`timescale 1ns/1ps
`default_nettype none
module soi_link_properties (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic sclk,
   input  wire logic sen_n,
   input  wire logic sdi,
   input  wire logic sdo_out,
   input  wire logic sdo_oe,
   input  wire logic sdo
);
   logic       sclk_q;
   logic [4:0] nrise;
   logic [4:0] cnt_now;

   ////////////////////////////////////////////////////////////////////////////////
   // rising link edges seen so far in this frame, the current one included
   assign cnt_now = nrise + {4'h0, sclk & ~sclk_q};

   // oversample the link clock with pclk, the host derives it from pclk anyway
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q <= 1'b0;
         nrise  <= 5'h00;
      end else begin
         sclk_q <= sclk;
         nrise  <= sen_n ? 5'h00 : cnt_now;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////////////
   // link clock stands low between frames
   a_idle_clock_low: assert property (sen_n |-> !sclk)
      else $error("link clock moved outside a frame");
   a_first_rise_gap: assert property ($fell(sen_n) |-> !sclk [*4] ##1 sclk)
      else $error("first link edge not four cycles after frame start");
   a_clock_high_width: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("link clock high phase not four cycles");
   a_rise_spacing: assert property (($rose(sclk) && cnt_now != 5'h10) |-> ##8 $rose(sclk))
      else $error("link clock period not eight cycles");
   a_last_then_end: assert property (($rose(sclk) && cnt_now == 5'h10) |-> ##[5:12] $rose(sen_n))
      else $error("frame not closed after sixteenth edge");
   a_frame_bit_count: assert property ($rose(sen_n) |-> nrise == 5'h10)
      else $error("frame did not carry sixteen bits");
   // data only moves while the link clock is low, so the device samples a settled bit
   a_sdi_stable_high: assert property (sclk |-> $stable(sdi))
      else $error("host data changed while link clock high");
   a_readback_start: assert property ($rose(sdo_oe) |-> cnt_now == 5'h08)
      else $error("read-back drive not started at eighth edge");
   a_readback_window: assert property (sdo_oe |-> (!sen_n && cnt_now >= 5'h08))
      else $error("read-back line driven outside its window");
   // an undriven read-back line settles at its pull-down level
   a_line_resolve: assert property (sdo == (sdo_oe && sdo_out))
      else $error("read-back line not resolved from device drive");

   cover property ($rose(sdo_oe));
   cover property ($rose(sen_n));
   cover property ($rose(sen_n) ##[1:300] $rose(sen_n));
endmodule
`default_nettype wire

// *** verif/test_serial_output_interface_config.sv ***
// testbench: host and device ends joined over the configuration link
`timescale 1ns/1ps
`default_nettype none
module test_serial_output_interface_config
   import soi_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr;
   soi_decim_t  decim_mode = SOI_BYPASS;
   logic        ret_en, fsrc, fdiv, fpin, map_en, b20, unsup;
   logic [2:0]  res_sel, dly_steps;
   logic [4:0]  width;
   logic [1:0]  dly_sel;
   int          num_errors = 0;
   int          check_count = 0;

   soi_link_if link_bus ();

   always #50 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////////
   soi_host u_soi_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link_bus));

   soi_device u_soi_device (.link(link_bus), .presetn(presetn), .decim_mode(decim_mode),
      .returned_clock_input_enable(ret_en), .frame_clock_source_select(fsrc),
      .frame_clock_divide_select(fdiv), .frame_clock_pin_enable(fpin),
      .mapper_enable(map_en), .twenty_bit_output_enable(b20),
      .mapper_resolution_select(res_sel), .output_width(width),
      .resolution_unsupported(unsup), .output_clock_delay_select(dly_sel),
      .output_clock_delay_steps(dly_steps));

   soi_link_properties u_soi_link_properties (.pclk(pclk), .presetn(presetn),
      .sclk(link_bus.sclk), .sen_n(link_bus.sen_n), .sdi(link_bus.sdi),
      .sdo_out(link_bus.sdo_out), .sdo_oe(link_bus.sdo_oe), .sdo(link_bus.sdo));

   ////////////////////////////////////////////////////////////////////////////////
   // verdict and comparisons
   task automatic end_of_test();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk_bus(input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t bus exp %h got %h", $time, e, g);
      end
   endtask

   task automatic chk_dev(input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t pins exp %h got %h", $time, e, g);
      end
   endtask

   // one apb transfer, entered just after a rising edge; an idle cycle follows
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) num_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // poll for completion, clear the sticky flag and fetch the read byte
   task automatic wait_done(output logic [7:0] q);
      logic [31:0] r;
      logic        e;
      int          n;
      n = 0;
      do begin
         apb(1'b0, SOI_APB_STAT, 32'h0, r, e);
         n++;
      end while (r[SOI_DONE_BIT] !== 1'b1 && n < 200);
      chk_bus(32'h2, r & 32'h3);
      apb(1'b1, SOI_APB_STAT, 32'h2, r, e);
      apb(1'b0, SOI_APB_STAT, 32'h0, r, e);
      chk_bus(32'h0, r & 32'h3);
      apb(1'b0, SOI_APB_RDAT, 32'h0, r, e);
      q = r[7:0];
   endtask

   task automatic lop(input logic rdf, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      logic [31:0] r;
      logic        e;
      apb(1'b1, SOI_APB_CMD, {16'h0, rdf, a, d}, r, e);
      wait_done(q);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      lop(1'b0, a, d, q);
   endtask

   task automatic rchk(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] q;
      lop(1'b1, a, 8'h00, q);
      chk_bus({24'h0, e}, {24'h0, q});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      rchk(SOI_ADDR_CLKBUF, 8'h00);
      rchk(SOI_ADDR_FRAME_CLOCK, 8'h00);
      rchk(SOI_ADDR_RES, 8'h00);
      rchk(SOI_ADDR_DLY, 8'h00);
      chk_dev(8'h0e, {3'h0, width});
      apb(1'b0, 12'h00c, 32'h0, r, e);
      chk_bus(32'h1, {31'h0, e});
      chk_bus(32'h0, r);
   endtask

   task automatic t_clkbuf();
      wr(SOI_ADDR_CLKBUF, 8'hff);
      wr(7'h1f, 8'h40);
      rchk(7'h1f, 8'h00);
      rchk(SOI_ADDR_CLKBUF, 8'h10);
      chk_dev(8'h01, {7'h0, ret_en});
      wr(SOI_ADDR_CLKBUF, 8'h00);
      chk_dev(8'h00, {7'h0, ret_en});
   endtask

   // source/divide pairs per mode, reserved bits set to prove they are dropped
   task automatic t_frame_clock();
      logic [31:0] rows;
      logic [7:0]  v;
      rows = 32'h12008280;
      for (int i = 0; i < 4; i++) begin
         v = rows[31 - 8 * i -: 8];
         decim_mode <= soi_decim_t'(i < 2 ? i : 2);
         wr(SOI_ADDR_FRAME_CLOCK, v | 8'h6d);
         rchk(SOI_ADDR_FRAME_CLOCK, v);
         chk_dev({5'h0, v[7], v[4], v[1]}, {5'h0, fsrc, fdiv, fpin});
      end
   endtask

   task automatic t_res();
      logic [4:0] w;
      for (int m = 0; m < 3; m++) begin
         decim_mode <= soi_decim_t'(m);
         for (int c = 0; c < 8; c++) begin
            wr(SOI_ADDR_RES, {m == 0, 1'b0, 3'(c), 3'h0});
            w = (c == 1) ? 5'h10 : (c == 2) ? 5'h0e : 5'h12;
            chk_dev({3'(c), w}, {res_sel, width});
            chk_dev({7'h0, c > 2}, {7'h0, unsup});
         end
      end
      wr(SOI_ADDR_RES, 8'h88);
      chk_dev(8'h10, {3'h0, width});
      decim_mode <= SOI_BYPASS;
      wr(SOI_ADDR_RES, 8'h08);
      chk_dev(8'h0e, {3'h0, width});
      wr(SOI_ADDR_RES, 8'h4f);
      rchk(SOI_ADDR_RES, 8'h48);
      chk_dev(8'h14, {3'h0, width});
      chk_dev(8'h01, {6'h0, map_en, b20});
   endtask

   task automatic t_dly();
      logic [11:0] st;
      st = 12'b010_001_111_000;
      for (int c = 0; c < 4; c++) begin
         wr(SOI_ADDR_DLY, {2'h3, 2'(c), 4'hf});
         rchk(SOI_ADDR_DLY, {2'h0, 2'(c), 4'h0});
         chk_dev({3'h0, 2'(c), st[3 * c +: 3]}, {3'h0, dly_sel, dly_steps});
      end
   endtask

   // a second command while busy is dropped without error
   task automatic t_busy();
      logic [31:0] r;
      logic        e;
      logic [7:0]  q;
      apb(1'b1, SOI_APB_CMD, {16'h0, 1'b0, SOI_ADDR_FRAME_CLOCK, 8'h02}, r, e);
      apb(1'b1, SOI_APB_CMD, {16'h0, 1'b0, SOI_ADDR_FRAME_CLOCK, 8'h80}, r, e);
      chk_bus(32'h0, {31'h0, e});
      apb(1'b0, SOI_APB_STAT, 32'h0, r, e);
      chk_bus(32'h1, r & 32'h1);
      wait_done(q);
      rchk(SOI_ADDR_FRAME_CLOCK, 8'h02);
      chk_dev(8'h01, {6'h0, fsrc, fpin});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_clkbuf();
      t_frame_clock();
      t_res();
      t_dly();
      t_busy();
      end_of_test();
   end

   // watchdog: the whole sequence needs about a millisecond
   initial begin
      #3000000;
      num_errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
